// *** common/gpio_port_pkg.sv ***
// package: register map, field layout and reset values of the gpio port
package gpio_port_pkg;
    // ========================================================
    // register word indices; the byte address is four times the index
    localparam logic [7:0] port0_direction_off    = 8'hB8;
    localparam logic [7:0] port1_direction_off    = 8'hC1;
    localparam logic [7:0] port2_direction_off    = 8'hC2;
    localparam logic [7:0] port5_direction_off    = 8'hC5;
    localparam logic [7:0] port0_data_off         = 8'hD0;
    localparam logic [7:0] port1_data_off         = 8'hD1;
    localparam logic [7:0] port2_data_off         = 8'hD2;
    localparam logic [7:0] port5_data_off         = 8'hD5;
    localparam logic [7:0] port0_pullup_off       = 8'hE0;
    localparam logic [7:0] port1_pullup_off       = 8'hE1;
    localparam logic [7:0] port2_pullup_off       = 8'hE2;
    localparam logic [7:0] port5_pullup_off       = 8'hE5;
    localparam logic [7:0] open_drain_control_off = 8'hE9;
    localparam logic [7:0] irq_enable_off         = 8'hF0;
    localparam logic [7:0] irq_flag_off           = 8'hF4;
    localparam logic [7:0] edge_select_off        = 8'hF8;
    localparam logic [7:0] pin_function_off       = 8'hFC;
    // ========================================================
    // implemented bit masks per port
    localparam logic [7:0] port0_mask = 8'h01;
    localparam logic [7:0] port1_mask = 8'h0D;
    localparam logic [7:0] port1_rd_mask = 8'h0F;
    localparam logic [7:0] port2_mask = 8'h3F;
    localparam logic [7:0] port5_mask = 8'h10;
    // ========================================================
    // field positions
    localparam int ext_irq_bit     = 0;
    localparam int timer_irq_bit   = 4;
    localparam int counter_irq_bit = 5;
    localparam int open_drain_bit  = 0;
    localparam int buzzer_sel_bit  = 0;
    localparam int pwm_sel_bit     = 1;
    localparam int counter_en_bit  = 2;
    localparam logic [7:0] irq_mask = 8'h31;
    // ========================================================
    // reset values and edge select codes
    localparam logic [7:0] reg_reset  = 8'h00;
    localparam logic [1:0] edge_reset = 2'h2;
    localparam logic [1:0] edge_rise  = 2'h1;
    localparam logic [1:0] edge_fall  = 2'h2;
    localparam logic [1:0] edge_both  = 2'h3;
    // ========================================================
    // high clock option codes
    typedef enum logic [2:0] {
        hclk_ihrc     = 3'h0,
        hclk_rc       = 3'h1,
        hclk_32k      = 3'h2,
        hclk_4m       = 3'h3,
        hclk_12m      = 3'h4,
        hclk_internal_rc_with_rtc = 3'h5
    } high_clk_e;
endpackage : gpio_port_pkg

// *** verification/pin_model.sv ***
// pad model: resolves each pin level from drive, pull-ups and outside sources
`timescale 1ns/10ps
module pin_model #(
    parameter logic [7:0] ext_pull = 8'h00
) (
    input  wire logic       pclk,
    input  wire logic [7:0] drv_out,
    input  wire logic [7:0] drv_oe,
    input  wire logic [7:0] pull_on,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin
);
    logic [7:0] float_q = 8'h00;
    logic [7:0] up;
    // ========================================================
    // a pad left open wanders, so no check may lean on it
    always @(posedge pclk) float_q <= ~float_q;
    assign up  = pull_on | ext_pull;
    assign pin = (drv_oe & drv_out) | (~drv_oe & ext_en & ext_val)
               | (~drv_oe & ~ext_en & (up | float_q));
endmodule : pin_model

// *** verification/tb_top.sv ***
// testbench: apb register tests, pin muxing and request flags
`timescale 1ns/10ps
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rst_opt = 1'b0;
    logic [2:0]  hclk_opt = 3'h0;
    logic        tmr_ovf = 1'b0;
    logic        cnt_ovf = 1'b0;
    logic        pwm_lvl = 1'b0;
    logic        bz_lvl = 1'b0;
    logic [7:0]  p_in [4];
    logic [7:0]  p_out [4];
    logic [7:0]  p_oe [4];
    logic [7:0]  p_pull [4];
    logic [7:0]  ext_en [4] = '{default: 8'hFF};
    logic [7:0]  ext_val [4] = '{default: 8'h00};
    logic        ext_rst_n;
    logic        osc_in;
    logic        osc_out;
    logic        vec;
    logic [7:0]  rd;
    logic        err;
    int          bad_count = 0;
    int          num_checks = 0;

    always #5 pclk = ~pclk;

    gpio_port_block i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reset_pin_option(rst_opt),
        .high_clk_option(hclk_opt), .timer_overflow(tmr_ovf),
        .counter_overflow(cnt_ovf), .pwm_out_pin(pwm_lvl),
        .buzzer_out_pin(bz_lvl), .port0_in(p_in[0]), .port1_in(p_in[1]),
        .port2_in(p_in[2]), .port5_in(p_in[3]), .port0_out(p_out[0]),
        .port0_oe(p_oe[0]), .port1_out(p_out[1]), .port1_oe(p_oe[1]),
        .port2_out(p_out[2]), .port2_oe(p_oe[2]), .port5_out(p_out[3]),
        .port5_oe(p_oe[3]), .port0_pull_on(p_pull[0]),
        .port1_pull_on(p_pull[1]), .port2_pull_on(p_pull[2]),
        .port5_pull_on(p_pull[3]), .ext_reset_n(ext_rst_n),
        .osc_in_take(osc_in), .osc_out_take(osc_out), .irq_vector_req(vec)
    );

    // only the open-drain pin carries an outside pull-up resistor
    for (genvar g = 0; g < 4; g++) begin : g_pin
        pin_model #(.ext_pull(g == 1 ? 8'h01 : 8'h00)) i_pin (
            .pclk(pclk), .drv_out(p_out[g]), .drv_oe(p_oe[g]),
            .pull_on(p_pull[g]), .ext_en(ext_en[g]), .ext_val(ext_val[g]),
            .pin(p_in[g])
        );
    end

    // ========================================================
    // shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s: got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {22'h0, a, 2'h0};
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
        @(posedge pclk);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [7:0] e,
                        input string m);
        apb(1'b0, a, 8'h00);
        chk(rd, e, m);
    endtask : rchk

    task automatic wait_clk(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_clk

    task automatic pulse(input logic tmr);
        @(posedge pclk);
        tmr_ovf <= tmr;
        cnt_ovf <= ~tmr;
        @(posedge pclk);
        tmr_ovf <= 1'b0;
        cnt_ovf <= 1'b0;
        wait_clk(2);
    endtask : pulse

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // ========================================================
    // scenarios
    task automatic t_reset;
        logic [7:0] offs [10] = '{gpio_port_pkg::port0_direction_off,
            gpio_port_pkg::port1_direction_off,
            gpio_port_pkg::port2_direction_off,
            gpio_port_pkg::port5_direction_off,
            gpio_port_pkg::port2_data_off, gpio_port_pkg::port0_pullup_off,
            gpio_port_pkg::port1_pullup_off, gpio_port_pkg::port2_pullup_off,
            gpio_port_pkg::port5_pullup_off,
            gpio_port_pkg::open_drain_control_off};
        for (int i = 0; i < 4; i++) begin
            chk(p_oe[i], 8'h00, "oe at reset");
            chk(p_pull[i], 8'h00, "pull at reset");
        end
        for (int i = 0; i < 10; i++) rchk(offs[i], 8'h00, "reset value");
        rchk(gpio_port_pkg::edge_select_off, 8'h10, "edge reset");
        apb(1'b0, 8'h80, 8'h00);
        chk({7'h0, err}, 8'h01, "unmapped error");
        chk(rd, 8'h00, "unmapped data");
        $display("t_reset done");
    endtask : t_reset

    task automatic t_port2;
        wr(gpio_port_pkg::port0_data_off, 8'hFF);
        chk(p_out[0], 8'h01, "p0 latch");
        wr(gpio_port_pkg::port2_direction_off, 8'hFF);
        wr(gpio_port_pkg::port2_data_off, 8'h2A);
        wr(gpio_port_pkg::port2_pullup_off, 8'hFF);
        rchk(gpio_port_pkg::port2_direction_off, 8'h3F, "dir");
        chk(p_oe[2], 8'h3F, "oe out");
        chk(p_out[2] & 8'h3F, 8'h2A, "drive");
        chk(p_pull[2], 8'h00, "pull in out mode");
        rchk(gpio_port_pkg::port2_data_off, 8'h2A, "latch read");
        rchk(gpio_port_pkg::port2_pullup_off, 8'h00, "pullup wo");
        wr(gpio_port_pkg::port2_direction_off, 8'h00);
        chk(p_oe[2], 8'h00, "oe in");
        chk(p_pull[2], 8'h3F, "pull in input");
        ext_en[2]  <= 8'h0C;
        ext_val[2] <= 8'h04;
        wait_clk(4);
        rchk(gpio_port_pkg::port2_data_off, 8'h37, "pin read");
        wr(gpio_port_pkg::port2_pullup_off, 8'h00);
        chk(p_pull[2], 8'h00, "pull off");
        ext_en[2]  <= 8'hFF;
        ext_val[2] <= 8'h00;
        $display("t_port2 done");
    endtask : t_port2

    task automatic t_port1;
        wr(gpio_port_pkg::port1_direction_off, 8'hFF);
        rchk(gpio_port_pkg::port1_direction_off, 8'h0D, "p1 dir");
        chk(p_oe[1] & 8'h02, 8'h00, "p1.1 no drive");
        wr(gpio_port_pkg::port1_direction_off, 8'h00);
        wr(gpio_port_pkg::port1_pullup_off, 8'hFF);
        chk(p_pull[1], 8'h0D, "p1 pull");
        wr(gpio_port_pkg::port1_pullup_off, 8'h00);
        ext_val[1] <= 8'h02;
        wait_clk(4);
        rchk(gpio_port_pkg::port1_data_off, 8'h02, "p1.1 pin");
        chk({7'h0, ext_rst_n}, 8'h01, "no reset fn");
        ext_val[1] <= 8'h00;
        rst_opt    <= 1'b1;
        wait_clk(4);
        rchk(gpio_port_pkg::port1_data_off, 8'h02, "p1.1 reads 1");
        chk({7'h0, ext_rst_n}, 8'h00, "reset low");
        ext_val[1] <= 8'h02;
        wait_clk(4);
        chk({7'h0, ext_rst_n}, 8'h01, "reset high");
        rst_opt    <= 1'b0;
        ext_val[1] <= 8'h00;
        $display("t_port1 done");
    endtask : t_port1

    task automatic t_odrain;
        wr(gpio_port_pkg::port1_direction_off, 8'h01);
        wr(gpio_port_pkg::port1_data_off, 8'h00);
        wr(gpio_port_pkg::open_drain_control_off, 8'h01);
        ext_en[1] <= 8'hFE;
        chk(p_oe[1] & 8'h01, 8'h01, "od sink");
        chk(p_out[1] & 8'h01, 8'h00, "od low");
        wr(gpio_port_pkg::port1_data_off, 8'h01);
        chk(p_oe[1] & 8'h01, 8'h00, "od release");
        chk(p_pull[1] & 8'h01, 8'h00, "od no pull");
        chk(p_in[1] & 8'h01, 8'h01, "od pulled high");
        rchk(gpio_port_pkg::open_drain_control_off, 8'h00, "od wo");
        wr(gpio_port_pkg::open_drain_control_off, 8'h00);
        chk(p_oe[1] & 8'h01, 8'h01, "od off mode");
        chk(p_out[1] & 8'h01, 8'h01, "od off high");
        wr(gpio_port_pkg::port1_direction_off, 8'h00);
        wr(gpio_port_pkg::port1_data_off, 8'h00);
        ext_en[1] <= 8'hFF;
        $display("t_odrain done");
    endtask : t_odrain

    task automatic t_osc;
        logic [2:0] o;
        for (int i = 0; i < 6; i++) begin
            o = 3'(i);
            hclk_opt <= o;
            wait_clk(2);
            chk({7'h0, osc_in}, {7'h0, o != gpio_port_pkg::hclk_ihrc},
                "osc in");
            chk({7'h0, osc_out}, {7'h0, o != gpio_port_pkg::hclk_ihrc &&
                o != gpio_port_pkg::hclk_rc}, "osc out");
        end
        hclk_opt <= 3'h0;
        $display("t_osc done");
    endtask : t_osc

    task automatic t_buzz;
        logic b;
        wr(gpio_port_pkg::port5_direction_off, 8'h10);
        chk(p_oe[3], 8'h10, "p5 out");
        for (int m = 0; m < 2; m++) begin
            wr(gpio_port_pkg::pin_function_off, m == 1 ? 8'h07 : 8'h05);
            for (int j = 0; j < 2; j++) begin
                b = j[0];
                bz_lvl  <= b;
                pwm_lvl <= ~b;
                wait_clk(2);
                chk(p_out[3] & 8'h10, ((m == 1) ? ~b : b) ? 8'h10 : 8'h00,
                    "p5.4 source");
            end
        end
        wr(gpio_port_pkg::pin_function_off, 8'h00);
        wr(gpio_port_pkg::port5_direction_off, 8'h00);
        $display("t_buzz done");
    endtask : t_buzz

    task automatic t_ext;
        logic r;
        logic f;
        wr(gpio_port_pkg::irq_enable_off, 8'h01);
        for (int c = 1; c < 4; c++) begin
            r = (2'(c) == gpio_port_pkg::edge_rise) || (c == 3);
            f = (2'(c) == gpio_port_pkg::edge_fall) || (c == 3);
            wr(gpio_port_pkg::edge_select_off, {3'h0, 2'(c), 3'h0});
            wr(gpio_port_pkg::irq_flag_off, 8'h00);
            ext_val[0] <= 8'h01;
            wait_clk(4);
            chk({7'h0, vec}, {7'h0, r}, "ext vector");
            rchk(gpio_port_pkg::irq_flag_off, {7'h0, r}, "rise");
            wr(gpio_port_pkg::irq_flag_off, 8'h00);
            ext_val[0] <= 8'h00;
            wait_clk(4);
            rchk(gpio_port_pkg::irq_flag_off, {7'h0, f}, "fall");
        end
        wr(gpio_port_pkg::irq_enable_off, 8'h00);
        wr(gpio_port_pkg::irq_flag_off, 8'h00);
        wr(gpio_port_pkg::edge_select_off, 8'h10);
        $display("t_ext done");
    endtask : t_ext

    // service code must look at enable and flag together
    task automatic t_ovf;
        pulse(1'b1);
        rchk(gpio_port_pkg::irq_flag_off, 8'h10, "timer flag");
        chk({7'h0, vec}, 8'h00, "no vector");
        wr(gpio_port_pkg::irq_enable_off, 8'h30);
        wait_clk(3);
        chk({7'h0, vec}, 8'h00, "stale flag");
        pulse(1'b0);
        chk({7'h0, vec}, 8'h01, "counter vector");
        rchk(gpio_port_pkg::irq_flag_off, 8'h30, "both flags");
        wr(gpio_port_pkg::irq_flag_off, 8'h10);
        wait_clk(2);
        chk({7'h0, vec}, 8'h00, "cleared");
        rchk(gpio_port_pkg::irq_flag_off, 8'h10, "timer kept");
        pulse(1'b1);
        chk({7'h0, vec}, 8'h01, "timer vector");
        wr(gpio_port_pkg::irq_flag_off, 8'h00);
        wait_clk(2);
        chk({7'h0, vec}, 8'h00, "all clear");
        $display("t_ovf done");
    endtask : t_ovf

    // ========================================================
    // main sequence and watchdog
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_port2();
        t_port1();
        t_odrain();
        t_osc();
        t_buzz();
        t_ext();
        t_ovf();
        results();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end
endmodule : tb_top

// *** verilog/gpio_port_block.sv ***
// gpio port block: apb registers, pin muxing and interrupt request flags
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module gpio_port_block (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        reset_pin_option,
    input  wire logic [2:0]  high_clk_option,
    input  wire logic        timer_overflow,
    input  wire logic        counter_overflow,
    input  wire logic        pwm_out_pin,
    input  wire logic        buzzer_out_pin,
    input  wire logic [7:0]  port0_in,
    input  wire logic [7:0]  port1_in,
    input  wire logic [7:0]  port2_in,
    input  wire logic [7:0]  port5_in,
    output logic      [7:0]  port0_out,
    output logic      [7:0]  port0_oe,
    output logic      [7:0]  port1_out,
    output logic      [7:0]  port1_oe,
    output logic      [7:0]  port2_out,
    output logic      [7:0]  port2_oe,
    output logic      [7:0]  port5_out,
    output logic      [7:0]  port5_oe,
    output logic      [7:0]  port0_pull_on,
    output logic      [7:0]  port1_pull_on,
    output logic      [7:0]  port2_pull_on,
    output logic      [7:0]  port5_pull_on,
    output logic             ext_reset_n,
    output logic             osc_in_take,
    output logic             osc_out_take,
    output logic             irq_vector_req
);
    // ========================================================
    // state
    typedef struct packed {
        logic [7:0] dir0, dir1, dir2, dir5;
        logic [7:0] dat0, dat1, dat2, dat5;
        logic [7:0] pu0, pu1, pu2, pu5;
        logic [7:0] odc;
        logic [7:0] ien;
        logic [7:0] flag;
        logic [7:0] vec;   // flag raised while its enable was set
        logic [1:0] edge_sel;
        logic [7:0] pinfn;
        logic [7:0] s1_0, s1_1, s1_2, s1_5;
        logic [7:0] s2_0, s2_1, s2_2, s2_5;
        logic       s1_rst, s2_rst;
        logic       int_prev;
        logic [31:0] rdata;
    } state_s;

    state_s q, d;

    function automatic logic [7:0] mix(input logic [7:0] dir,
                                       input logic [7:0] pin,
                                       input logic [7:0] lat,
                                       input logic [7:0] msk);
        mix = ((dir & lat) | (~dir & pin)) & msk;
    endfunction : mix

    // ========================================================
    // combinational
    logic       wr_en;
    logic       rd_en;
    logic [7:0] wb;
    logic [7:0] rb;
    logic       hit;
    logic       int_pin;
    logic       ext_edge;
    logic [7:0] ev;
    logic       od_on;
    logic       ctr_en;
    logic [7:0] p1rd;
    logic [7:0] clr;
    logic [7:0] idx;

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign wb    = pwdata[7:0];
    assign idx   = paddr[9:2];
    assign int_pin = q.s2_0[0];
    assign od_on   = q.odc[gpio_port_pkg::open_drain_bit];
    assign ctr_en  = q.pinfn[gpio_port_pkg::counter_en_bit];

    always_comb begin
        d = q;
        ev = 8'h00;
        clr = 8'h00;
        hit = 1'b1;
        rb = 8'h00;
        ext_edge = 1'b0;
        // two-stage sync for all pins
        d.s1_0 = port0_in;
        d.s1_1 = port1_in;
        d.s1_2 = port2_in;
        d.s1_5 = port5_in;
        d.s2_0 = q.s1_0;
        d.s2_1 = q.s1_1;
        d.s2_2 = q.s1_2;
        d.s2_5 = q.s1_5;
        d.s1_rst = port1_in[1];
        d.s2_rst = q.s1_rst;
        d.int_prev = int_pin;
        // external edge only while the external interrupt enable bit (ien bit 0) is set
        if (q.ien[gpio_port_pkg::ext_irq_bit]) begin
            case (q.edge_sel)
                gpio_port_pkg::edge_rise: ext_edge = int_pin & ~q.int_prev;
                gpio_port_pkg::edge_fall: ext_edge = ~int_pin & q.int_prev;
                gpio_port_pkg::edge_both: ext_edge = int_pin ^ q.int_prev;
                default:                  ext_edge = 1'b0;
            endcase
        end
        ev[gpio_port_pkg::ext_irq_bit]     = ext_edge;
        ev[gpio_port_pkg::timer_irq_bit]   = timer_overflow;
        ev[gpio_port_pkg::counter_irq_bit] = counter_overflow;
        p1rd = mix(q.dir1 & gpio_port_pkg::port1_mask, q.s2_1, q.dat1,
                   gpio_port_pkg::port1_rd_mask);
        if (reset_pin_option) begin
            p1rd[1] = 1'b1;
        end
        case (idx)
            gpio_port_pkg::port0_direction_off: rb = q.dir0;
            gpio_port_pkg::port1_direction_off: rb = q.dir1;
            gpio_port_pkg::port2_direction_off: rb = q.dir2;
            gpio_port_pkg::port5_direction_off: rb = q.dir5;
            gpio_port_pkg::port0_data_off:
                rb = mix(q.dir0, q.s2_0, q.dat0, gpio_port_pkg::port0_mask);
            gpio_port_pkg::port1_data_off: rb = p1rd;
            gpio_port_pkg::port2_data_off:
                rb = mix(q.dir2, q.s2_2, q.dat2, gpio_port_pkg::port2_mask);
            gpio_port_pkg::port5_data_off:
                rb = mix(q.dir5, q.s2_5, q.dat5, gpio_port_pkg::port5_mask);
            gpio_port_pkg::port0_pullup_off,
            gpio_port_pkg::port1_pullup_off,
            gpio_port_pkg::port2_pullup_off,
            gpio_port_pkg::port5_pullup_off,
            gpio_port_pkg::open_drain_control_off: rb = 8'h00;
            gpio_port_pkg::irq_enable_off: rb = q.ien;
            gpio_port_pkg::irq_flag_off:   rb = q.flag;
            gpio_port_pkg::edge_select_off: rb = {3'h0, q.edge_sel, 3'h0};
            gpio_port_pkg::pin_function_off: rb = q.pinfn;
            default: hit = 1'b0;
        endcase
        if (paddr[31:10] != 22'h0 || paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end
        if (rd_en) begin
            d.rdata = hit ? {24'h000000, rb} : 32'h0;
        end
        if (wr_en && hit) begin
            case (idx)
                gpio_port_pkg::port0_direction_off:
                    d.dir0 = wb & gpio_port_pkg::port0_mask;
                gpio_port_pkg::port1_direction_off:
                    d.dir1 = wb & gpio_port_pkg::port1_mask;
                gpio_port_pkg::port2_direction_off:
                    d.dir2 = wb & gpio_port_pkg::port2_mask;
                gpio_port_pkg::port5_direction_off:
                    d.dir5 = wb & gpio_port_pkg::port5_mask;
                gpio_port_pkg::port0_data_off:
                    d.dat0 = wb & gpio_port_pkg::port0_mask;
                gpio_port_pkg::port1_data_off:
                    d.dat1 = wb & gpio_port_pkg::port1_mask;
                gpio_port_pkg::port2_data_off:
                    d.dat2 = wb & gpio_port_pkg::port2_mask;
                gpio_port_pkg::port5_data_off:
                    d.dat5 = wb & gpio_port_pkg::port5_mask;
                gpio_port_pkg::port0_pullup_off:
                    d.pu0 = wb & gpio_port_pkg::port0_mask;
                gpio_port_pkg::port1_pullup_off:
                    d.pu1 = wb & gpio_port_pkg::port1_mask;
                gpio_port_pkg::port2_pullup_off:
                    d.pu2 = wb & gpio_port_pkg::port2_mask;
                gpio_port_pkg::port5_pullup_off:
                    d.pu5 = wb & gpio_port_pkg::port5_mask;
                gpio_port_pkg::open_drain_control_off:
                    d.odc = wb & 8'h01;
                gpio_port_pkg::irq_enable_off:
                    d.ien = wb & gpio_port_pkg::irq_mask;
                gpio_port_pkg::irq_flag_off:
                    clr = ~wb & gpio_port_pkg::irq_mask;
                gpio_port_pkg::edge_select_off:
                    d.edge_sel = wb[4:3];
                gpio_port_pkg::pin_function_off:
                    d.pinfn = wb & 8'h07;
                default: d.pinfn = q.pinfn;
            endcase
        end
        // set beats clear; timer and counter flags set even with enable low
        d.flag = (q.flag & ~clr) | ev;
        // vectoring only for events seen while enabled
        d.vec = ((q.vec & ~clr) | (ev & q.ien)) & d.flag & d.ien;
    end

    // ========================================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.edge_sel <= gpio_port_pkg::edge_reset;
        end else begin
            q <= d;
        end
    end

    // ========================================================
    // pin drive
    logic p10_dir;
    logic osc_in_sel;
    logic osc_out_sel;
    assign p10_dir = q.dir1[0];
    always_comb begin
        osc_in_sel = 1'b0;
        osc_out_sel = 1'b0;
        case (high_clk_option)
            gpio_port_pkg::hclk_rc: osc_in_sel = 1'b1;
            gpio_port_pkg::hclk_32k,
            gpio_port_pkg::hclk_4m,
            gpio_port_pkg::hclk_12m,
            gpio_port_pkg::hclk_internal_rc_with_rtc: begin
                osc_in_sel = 1'b1;
                osc_out_sel = 1'b1;
            end
            default: osc_in_sel = 1'b0;
        endcase
    end

    always_comb begin
        port0_out = q.dat0;
        port0_oe  = q.dir0;
        port2_out = q.dat2;
        port2_oe  = q.dir2;
        port5_out = q.dat5;
        port5_oe  = q.dir5;
        port1_out = q.dat1 & gpio_port_pkg::port1_mask;
        port1_oe  = q.dir1 & gpio_port_pkg::port1_mask;
        // open drain: drive only a low; mode otherwise from direction
        if (od_on) begin
            port1_out[0] = 1'b0;
            port1_oe[0]  = p10_dir & ~q.dat1[0];
        end
        // oscillator pins are released to the analog pads
        if (osc_in_sel) begin
            port1_oe[3] = 1'b0;
        end
        if (osc_out_sel) begin
            port1_oe[2] = 1'b0;
        end
        if (ctr_en && q.pinfn[gpio_port_pkg::pwm_sel_bit]) begin
            port5_out[4] = pwm_out_pin;
        end else if (ctr_en && q.pinfn[gpio_port_pkg::buzzer_sel_bit]) begin
            port5_out[4] = buzzer_out_pin;
        end
        // a pull-up on an output pin would fight the driver
        port0_pull_on = q.pu0 & ~q.dir0;
        port1_pull_on = q.pu1 & ~q.dir1 & gpio_port_pkg::port1_mask;
        port2_pull_on = q.pu2 & ~q.dir2;
        port5_pull_on = q.pu5 & ~q.dir5;
        if (od_on) begin
            port1_pull_on[0] = 1'b0;
        end
    end

    assign ext_reset_n  = reset_pin_option ? q.s2_rst : 1'b1;
    assign osc_in_take  = osc_in_sel;
    assign osc_out_take = osc_out_sel;
    assign irq_vector_req = |q.vec;
    assign prdata  = q.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // ========================================================
    // checks
    property p_dir_reset;
        @(posedge pclk) $rose(presetn) |-> (port0_oe == 8'h00
            && port2_oe == 8'h00 && port5_oe == 8'h00);
    endproperty
    a_dir_reset: assert property (p_dir_reset)
        else $error("outputs enabled after reset");

    property p_pull_input;
        @(posedge pclk) disable iff (!presetn)
            (port2_pull_on & port2_oe) == 8'h00;
    endproperty
    a_pull_input: assert property (p_pull_input)
        else $error("pull-up active on output pin");

    property p_in_only;
        @(posedge pclk) disable iff (!presetn)
            !port1_oe[1] && !port1_pull_on[1];
    endproperty
    a_in_only: assert property (p_in_only)
        else $error("input-only pin driven or pulled");

    property p_od_high;
        @(posedge pclk) disable iff (!presetn)
            (od_on && q.dat1[0]) |-> !port1_oe[0];
    endproperty
    a_od_high: assert property (p_od_high)
        else $error("open drain drove a high");

    property p_od_wo;
        @(posedge pclk) disable iff (!presetn)
            (rd_en && idx == gpio_port_pkg::open_drain_control_off)
            |=> prdata == 32'h00000000;
    endproperty
    a_od_wo: assert property (p_od_wo)
        else $error("open drain register readable");

    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
            counter_overflow |=> q.flag[gpio_port_pkg::counter_irq_bit];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("counter flag not set by overflow");

    property p_stale;
        @(posedge pclk) disable iff (!presetn)
            (!q.ien[gpio_port_pkg::counter_irq_bit] && !q.vec[5]
             && !counter_overflow) ##1 !counter_overflow |-> !q.vec[5];
    endproperty
    a_stale: assert property (p_stale)
        else $error("stale flag started vectoring");

    property p_p11;
        @(posedge pclk) disable iff (!presetn)
            (reset_pin_option && rd_en
             && idx == gpio_port_pkg::port1_data_off)
            |=> prdata[1];
    endproperty
    a_p11: assert property (p_p11)
        else $error("input-only bit not read as one");

    property p_edge_reset;
        @(posedge pclk) $rose(presetn) |-> q.edge_sel == 2'h2;
    endproperty
    a_edge_reset: assert property (p_edge_reset)
        else $error("edge select reset wrong");
endmodule : gpio_port_block
